// ===== rtl/gprb_params.svh
// Offsets, field positions, reset values and timing counts of the global page register bank
`ifndef GPRB_PARAMS_SVH
`define GPRB_PARAMS_SVH
`define GPRB_GLOBAL_SPAN 8'h10
`define GPRB_UC_BASE 16'hA000
`define GPRB_OFF_ID_RST 4'h0
`define GPRB_OFF_PAGE 4'h1
`define GPRB_OFF_SW_FLT 4'h2
`define GPRB_OFF_REG_FLT 4'h3
`define GPRB_OFF_REG_EN 4'h4
`define GPRB_OFF_SW_EN 4'h5
`define GPRB_RST_BIT 7
`define GPRB_PAGE_W 2
`define GPRB_SW_FLT_W 4
`define GPRB_REG_W 7
`define GPRB_RST_PAGE 2'h0
`define GPRB_RST_REG_EN 7'h00
`define GPRB_RST_SW_EN 8'h00
`define GPRB_SW_EN_MASK 8'h9F
`define GPRB_RST_PULSE 4'h8
`endif

// ===== rtl/gprb_pkg.sv
// Types shared by the global page register bank
package gprb_pkg;
   typedef enum logic [1:0] {GPRB_IDLE, GPRB_HOST, GPRB_UC} gprb_grant_t;
   typedef logic [7:0] gprb_byte_t;
endpackage

// ===== rtl/gprb_access_if.sv
// Arbitrated byte access between arbiter and register file
`timescale 1ns/1ns
`default_nettype none
interface gprb_access_if;
   logic wr;
   logic [3:0] idx;
   logic [7:0] wdata;
   modport arb (output wr, output idx, output wdata);
   modport regs (input wr, input idx, input wdata);
endinterface
`default_nettype wire

// ===== rtl/gprb_regfile.sv
// Storage of writable global registers
`timescale 1ns/1ns
`default_nettype none
`include "gprb_params.svh"
module gprb_regfile (
   input wire logic clk_sys,
   input wire logic srst,
   gprb_access_if.regs acc,
   output logic [1:0] page,
   output logic [6:0] reg_en,
   output logic [7:0] sw_en,
   output logic rst_req
);
   import gprb_pkg::*;
   logic [1:0] next_page;
   logic [6:0] next_reg_en;
   logic [7:0] next_sw_en;
   logic next_rst_req;
   // Byte writes, reserved bits dropped
   always_comb begin
      next_page = page;
      next_reg_en = reg_en;
      next_sw_en = sw_en;
      next_rst_req = 1'b0;
      if (acc.wr) begin
         unique case (acc.idx)
            `GPRB_OFF_ID_RST: next_rst_req = acc.wdata[`GPRB_RST_BIT];
            `GPRB_OFF_PAGE: next_page = acc.wdata[1:0];
            `GPRB_OFF_REG_EN: next_reg_en = acc.wdata[6:0];
            `GPRB_OFF_SW_EN: next_sw_en = acc.wdata & `GPRB_SW_EN_MASK;
            default: ;
         endcase
      end
   end
   // Register stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         page <= `GPRB_RST_PAGE;
         reg_en <= `GPRB_RST_REG_EN;
         sw_en <= `GPRB_RST_SW_EN;
         rst_req <= 1'b0;
      end else begin
         page <= next_page;
         reg_en <= next_reg_en;
         sw_en <= next_sw_en;
         rst_req <= next_rst_req;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/gprb_bank.sv
// Global page register bank with serial-slave and microcontroller access
`timescale 1ns/1ns
`default_nettype none
`include "gprb_params.svh"
module gprb_bank #(
   parameter logic [6:0] CHIP_ID = 7'h11 // Arbitrary identifier value
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic host_start,
   input wire logic [7:0] host_addr,
   input wire logic host_req,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   output logic host_ack,
   output logic [7:0] host_rdata,
   output logic host_global,
   output logic [7:0] host_ptr,
   input wire logic uc_req,
   input wire logic uc_wr,
   input wire logic [15:0] uc_addr,
   input wire logic [7:0] uc_wdata,
   output logic uc_ack,
   output logic [7:0] uc_rdata,
   output logic uc_hit,
   input wire logic [3:0] sw_fault,
   input wire logic [6:0] reg_fault,
   output logic [1:0] page_sel,
   output logic [6:0] reg_on,
   output logic [7:0] sw_on,
   output logic sys_reset
);
   import gprb_pkg::*;
   gprb_access_if acc ();
   logic [3:0] sw_fault_m, sw_fault_s;
   logic [6:0] reg_fault_m, reg_fault_s;
   logic [1:0] page;
   logic [6:0] reg_en;
   logic [7:0] sw_en;
   logic rst_req;
   logic [7:0] next_host_ptr, next_host_rdata, next_uc_rdata;
   logic next_host_ack, next_uc_ack, next_host_global, next_uc_hit;
   gprb_grant_t grant;
   logic uc_in_window;
   logic host_take, uc_take;
   logic [3:0] rst_cnt, next_rst_cnt;
   logic next_sys_reset;
   // Microcontroller window base, upper twelve bits decoded
   localparam logic [15:0] UC_BASE = `GPRB_UC_BASE;

   // Read mux for a global offset
   function automatic gprb_byte_t read_global(input logic [3:0] idx);
      unique case (idx)
         `GPRB_OFF_ID_RST: read_global = {1'b0, CHIP_ID};
         `GPRB_OFF_PAGE: read_global = {6'h00, page};
         `GPRB_OFF_SW_FLT: read_global = {4'h0, sw_fault_s};
         `GPRB_OFF_REG_FLT: read_global = {1'b0, reg_fault_s};
         `GPRB_OFF_REG_EN: read_global = {1'b0, reg_en};
         `GPRB_OFF_SW_EN: read_global = sw_en;
         default: read_global = 8'h00;
      endcase
   endfunction

   // Global window test, used on the host side only
   function automatic logic is_global(input logic [7:0] off);
      is_global = off < `GPRB_GLOBAL_SPAN;
   endfunction

   // Fault pins come from analog blocks: two-stage sync
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sw_fault_m <= 4'h0;
         sw_fault_s <= 4'h0;
         reg_fault_m <= 7'h00;
         reg_fault_s <= 7'h00;
      end else begin
         sw_fault_m <= sw_fault;
         sw_fault_s <= sw_fault_m;
         reg_fault_m <= reg_fault;
         reg_fault_s <= reg_fault_m;
      end
   end

   assign uc_in_window = (uc_addr[15:4] == UC_BASE[15:4]);

   // Byte requests as the arbiter sees them
   assign host_take = host_req && !host_start;
   // No take in the answer cycle, so a request still standing there is not served twice
   assign uc_take = uc_req && !uc_ack;

   // Arbiter: serial slave has strict priority
   always_comb begin
      grant = GPRB_IDLE;
      if (host_take) begin
         grant = GPRB_HOST;
      end else if (uc_take) begin
         grant = GPRB_UC;
      end
      acc.wr = 1'b0;
      acc.idx = 4'h0;
      acc.wdata = host_wdata;
      unique case (grant)
         GPRB_HOST: begin
            acc.wr = host_wr && is_global(host_ptr);
            acc.idx = host_ptr[3:0];
         end
         GPRB_UC: begin
            acc.wr = uc_wr && uc_in_window;
            acc.idx = uc_addr[3:0];
            acc.wdata = uc_wdata;
         end
         GPRB_IDLE: ;
      endcase
   end

   gprb_regfile u_regs (
      .clk_sys(clk_sys),
      .srst(srst),
      .acc(acc),
      .page(page),
      .reg_en(reg_en),
      .sw_en(sw_en),
      .rst_req(rst_req)
   );

   // Host pointer, answer and read byte
   always_comb begin
      next_host_ptr = host_ptr;
      next_host_ack = 1'b0;
      next_host_rdata = host_rdata;
      next_host_global = host_global;
      if (host_start) begin
         next_host_ptr = host_addr;
         next_host_global = is_global(host_addr);
      end else if (grant == GPRB_HOST) begin
         next_host_ack = 1'b1;
         next_host_rdata = is_global(host_ptr) ? read_global(host_ptr[3:0]) : 8'h00;
         next_host_ptr = host_ptr + 8'h01;
         next_host_global = is_global(host_ptr + 8'h01);
      end
   end

   // Microcontroller answer and read byte
   always_comb begin
      next_uc_ack = 1'b0;
      next_uc_rdata = uc_rdata;
      next_uc_hit = uc_hit;
      if (grant == GPRB_UC) begin
         next_uc_ack = 1'b1;
         next_uc_hit = uc_in_window;
         next_uc_rdata = uc_in_window ? read_global(uc_addr[3:0]) : 8'h00;
      end
   end

   // Stretch the reset request into a pulse of fixed length
   always_comb begin
      next_rst_cnt = rst_cnt;
      if (rst_req) begin
         next_rst_cnt = `GPRB_RST_PULSE;
      end else if (rst_cnt != 4'h0) begin
         next_rst_cnt = rst_cnt - 4'h1;
      end
      next_sys_reset = (next_rst_cnt != 4'h0);
   end

   // Host side registers; pointer starts inside the global window
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         host_ptr <= 8'h00;
         host_ack <= 1'b0;
         host_rdata <= 8'h00;
         host_global <= 1'b1;
      end else begin
         host_ptr <= next_host_ptr;
         host_ack <= next_host_ack;
         host_rdata <= next_host_rdata;
         host_global <= next_host_global;
      end
   end

   // Microcontroller side registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         uc_ack <= 1'b0;
         uc_rdata <= 8'h00;
         uc_hit <= 1'b0;
      end else begin
         uc_ack <= next_uc_ack;
         uc_rdata <= next_uc_rdata;
         uc_hit <= next_uc_hit;
      end
   end

   // Reset pulse counter and its output flop
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rst_cnt <= 4'h0;
         sys_reset <= 1'b0;
      end else begin
         rst_cnt <= next_rst_cnt;
         sys_reset <= next_sys_reset;
      end
   end

   // Registered copies of page and enables for the power blocks
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         page_sel <= `GPRB_RST_PAGE;
         reg_on <= `GPRB_RST_REG_EN;
         sw_on <= `GPRB_RST_SW_EN;
      end else begin
         page_sel <= page;
         reg_on <= reg_en;
         sw_on <= sw_en;
      end
   end
endmodule
`default_nettype wire

// ===== sim/gprb_bank_asserts.sv
// Port checks of the global page register bank
`timescale 1ns/1ns
`default_nettype none
module gprb_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic host_start,
   input wire logic [7:0] host_addr,
   input wire logic host_req,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   input wire logic host_ack,
   input wire logic host_global,
   input wire logic [7:0] host_ptr,
   input wire logic uc_req,
   input wire logic [15:0] uc_addr,
   input wire logic uc_ack,
   input wire logic uc_hit,
   input wire logic sys_reset
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Host byte taken at this edge
   wire logic take = host_req && !host_start;
   // Reset pulse of exactly eight cycles
   sequence s_pulse;
      !sys_reset ##1 sys_reset [*8] ##1 !sys_reset;
   endsequence
   AST_ACK: assert property (take |=> host_ack) else $error("no host ack");
   AST_PTR: assert property (take |=> host_ptr == $past(host_ptr) + 8'h01)
      else $error("pointer step");
   AST_LOAD: assert property (host_start |=> host_ptr == $past(host_addr))
      else $error("pointer load");
   AST_GLB: assert property (host_global == (host_ptr < 8'h10)) else $error("global window");
   AST_RST: assert property (take && host_wr && host_ptr == 8'h00 && host_wdata[7]
      |-> ##[1:2] s_pulse) else $error("system reset pulse");
   AST_UC: assert property (uc_req && !host_req && !uc_ack |=> uc_ack)
      else $error("uc not served");
   AST_PRIO: assert property (host_req |=> !uc_ack) else $error("uc beat host");
   AST_HIT: assert property (uc_ack |-> uc_hit == ($past(uc_addr) >> 4 == 16'h0A00))
      else $error("uc window decode");
endmodule
bind gprb_bank gprb_chk u_chk (.clk_sys, .srst, .host_start, .host_addr, .host_req, .host_wr,
   .host_wdata, .host_ack, .host_global, .host_ptr, .uc_req, .uc_addr, .uc_ack, .uc_hit,
   .sys_reset);
`default_nettype wire

// ===== sim/gprb_host_model.sv
// Serial host master model on the bank's slave side
`timescale 1ns/1ns
`default_nettype none
module gprb_host_model (
   input wire logic clk_sys,
   output logic host_start,
   output logic [7:0] host_addr,
   output logic host_req,
   output logic host_wr,
   output logic [7:0] host_wdata,
   input wire logic host_ack,
   input wire logic [7:0] host_rdata
);
   // Idle bus at start
   initial {host_start, host_req, host_wr, host_addr, host_wdata} = 19'h0_0000;
   // Register address byte loads the pointer
   task automatic point(input logic [7:0] a);
      @(posedge clk_sys);
      host_start <= 1'h1;
      host_addr <= a;
      @(posedge clk_sys);
      host_start <= 1'h0;
      host_addr <= ~a; // Released lines show no stale value
   endtask
   // One byte per call, write of a one in bit 7 included
   task automatic xfer(input logic w, input logic [7:0] d, output logic [7:0] q, output logic k);
      @(posedge clk_sys);
      host_req <= 1'h1;
      host_wr <= w;
      host_wdata <= d;
      @(posedge clk_sys);
      host_req <= 1'h0;
      host_wdata <= ~d;
      @(negedge clk_sys);
      q = host_rdata;
      k = host_ack;
   endtask
endmodule
`default_nettype wire

// ===== sim/gprb_bank_tb.sv
// Self-checking bench of the global page register bank
`timescale 1ns/1ns
`default_nettype none
module gprb_bank_tb;
   import gprb_pkg::*;
   localparam logic [6:0] ID = 7'h2A; // Arbitrary identifier value
   logic clk_sys = 1'h0, srst = 1'h1, uc_req = 1'h0, uc_wr = 1'h0, k;
   logic host_start, host_req, host_wr, host_ack, host_global, uc_ack, uc_hit, sys_reset;
   logic [15:0] uc_addr = 16'h0000;
   logic [7:0] host_addr, host_wdata, host_rdata, host_ptr, uc_wdata = 8'h00, uc_rdata, sw_on;
   logic [3:0] sw_fault = 4'h0;
   logic [6:0] reg_fault = 7'h00, reg_on;
   logic [1:0] page_sel;
   gprb_byte_t q;
   int n_mismatch = 0, tests_run = 0;
   // Clock of 40 ns period
   always #20 clk_sys = ~clk_sys;
   gprb_bank #(.CHIP_ID(ID)) uut (.clk_sys, .srst, .host_start, .host_addr, .host_req, .host_wr,
      .host_wdata, .host_ack, .host_rdata, .host_global, .host_ptr, .uc_req, .uc_wr, .uc_addr,
      .uc_wdata, .uc_ack, .uc_rdata, .uc_hit, .sw_fault, .reg_fault, .page_sel, .reg_on, .sw_on,
      .sys_reset);
   gprb_host_model hm (.clk_sys, .host_start, .host_addr, .host_req, .host_wr, .host_wdata,
      .host_ack, .host_rdata);
   // Byte compare with counting
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   // Verdict and stop
   task automatic end_of_test;
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Host access at one offset
   task automatic hx(input logic [7:0] a, input logic w, input logic [7:0] d);
      hm.point(a);
      hm.xfer(w, d, q, k);
      chk("host_ack", 8'h01, {7'h00, k});
   endtask
   // Microcontroller access held until acknowledged
   task automatic uc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      uc_req <= 1'h1;
      uc_wr <= w;
      uc_addr <= a;
      uc_wdata <= d;
      @(negedge clk_sys);
      for (int i = 0; i < 20 && uc_ack !== 1'h1; i++) @(negedge clk_sys);
      q = uc_rdata;
      chk("uc_ack", 8'h01, {7'h00, uc_ack});
      @(posedge clk_sys);
      uc_req <= 1'h0;
      uc_wdata <= ~d;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'h0;
      hm.point(8'h00);
      for (int i = 0; i < 7; i++) begin
         hm.xfer(1'h0, 8'h00, q, k);
         chk("reset value", i == 0 ? {1'h0, ID} : 8'h00, q);
         chk("host_ptr", 8'(i + 1), host_ptr);
      end
      hx(8'h01, 1'h1, 8'hFF);
      hx(8'h01, 1'h0, 8'h00);
      chk("page", 8'h03, q);
      chk("page_sel", 8'h03, {6'h00, page_sel});
      hx(8'h00, 1'h1, 8'h7F);
      hx(8'h00, 1'h0, 8'h00);
      chk("id other page", {1'h0, ID}, q);
      hx(8'h20, 1'h0, 8'h00);
      chk("host_global", 8'h00, {7'h00, host_global});
      uc(1'h1, 16'hA004, 8'hFF);
      hx(8'h04, 1'h0, 8'h00);
      chk("reg_en", 8'h7F, q);
      chk("reg_on", 8'h7F, {1'h0, reg_on});
      hx(8'h05, 1'h1, 8'hFF);
      uc(1'h0, 16'hA005, 8'h00);
      chk("sw_en", 8'h9F, q);
      chk("sw_on", 8'h9F, sw_on);
      @(posedge clk_sys);
      sw_fault <= 4'hA;
      reg_fault <= 7'h55;
      repeat (4) @(posedge clk_sys);
      uc(1'h0, 16'hA002, 8'h00);
      chk("sw_fault", 8'h0A, q);
      hx(8'h03, 1'h0, 8'h00);
      chk("reg_fault", 8'h55, q);
      uc(1'h1, 16'hA014, 8'h00);
      @(negedge clk_sys);
      chk("uc_hit", 8'h00, {7'h00, uc_hit});
      chk("reg_on outside window", 8'h7F, {1'h0, reg_on});
      hm.point(8'h04);
      fork
         hm.xfer(1'h1, 8'h01, q, k);
         uc(1'h1, 16'hA004, 8'h02);
      join
      hx(8'h04, 1'h0, 8'h00);
      chk("arbitration order", 8'h02, q);
      hx(8'h00, 1'h1, 8'h80);
      for (int i = 0; i < 8 && sys_reset !== 1'h1; i++) @(negedge clk_sys);
      repeat (7) @(negedge clk_sys);
      chk("sys_reset", 8'h01, {7'h00, sys_reset});
      @(negedge clk_sys);
      chk("sys_reset end", 8'h00, {7'h00, sys_reset});
      hx(8'h00, 1'h0, 8'h00);
      chk("reset bit", {1'h0, ID}, q);
      end_of_test;
   end
   // Watchdog
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test;
   end
endmodule
`default_nettype wire
